// ### design/pcc_defines.svh
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// register locations
`define PCC_P3M_ADDR        8'hf7
`define PCC_PORT_CONFIGURATION_ADDR       8'h00
`define PCC_PORT_CONFIGURATION_BANK       4'hf

// mode register fields
`define PCC_P3M_P2PP_BIT    0
`define PCC_P3M_ANALOG_BIT  1
`define PCC_P3M_RESET       8'h00

// configuration register fields
`define PCC_PORT_CONFIGURATION_CMPOUT_BIT 0
`define PCC_PORT_CONFIGURATION_P1PP_BIT   1
`define PCC_PORT_CONFIGURATION_P0PP_BIT   2
`define PCC_PORT_CONFIGURATION_EMI_LSB    3
`define PCC_PORT_CONFIGURATION_OSC_BIT    7
`define PCC_PORT_CONFIGURATION_RESET      8'hfe

// interrupt edge select fields
`define PCC_IRQ_SEL_LO_BIT  6
`define PCC_IRQ_SEL_HI_BIT  7

// port 3 line positions
`define PCC_LINE_ONE        1
`define PCC_LINE_TWO        2
`define PCC_LINE_THREE      3
`define PCC_LINE_FOUR       4
`define PCC_LINE_FIVE       5
`define PCC_LINE_SEVEN      7

`endif

// ### design/pcc_pkg.sv
package pcc_pkg;

    // interrupt edge choice, from select bits {d7,d6}
    typedef enum logic [1:0] {
        PCC_EDGE_FALL = 2'b00,
        PCC_EDGE_RISE = 2'b01,
        PCC_EDGE_BOTH = 2'b10,
        PCC_EDGE_ALT  = 2'b11
    } pcc_edge_t;

    // power state of the core
    typedef enum logic [1:0] {
        PCC_PWR_RUN  = 2'b00,
        PCC_PWR_HALT = 2'b01,
        PCC_PWR_STOP = 2'b10
    } pcc_pwr_t;

endpackage : pcc_pkg

// ### design/pcc_edge_det.sv
`timescale 1ns/1ps
// edge detector for one comparator result line
module pcc_edge_det (
    input  wire logic            mclk,
    input  wire logic            resetn,
    input  wire logic            enable,
    input  wire logic            level,
    input  wire pcc_pkg::pcc_edge_t sel,
    output logic                 pulse
);
    logic level_q;

    // previous level, held while disabled
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            level_q <= 1'b0;
        end else if (enable) begin
            level_q <= level;
        end
    end

    // edge pick by select
    always_comb begin
        pulse = 1'b0;
        if (enable) begin
            unique case (sel)
                pcc_pkg::PCC_EDGE_FALL: pulse = level_q & ~level;
                pcc_pkg::PCC_EDGE_RISE: pulse = ~level_q & level;
                pcc_pkg::PCC_EDGE_BOTH: pulse = level_q ^ level;
                pcc_pkg::PCC_EDGE_ALT:  pulse = ~level_q & level;
            endcase
        end
    end
endmodule : pcc_edge_det

// ### design/pcc_cfg_regs.sv
`timescale 1ns/1ps
`include "pcc_defines.svh"
// write-only mode and configuration registers
module pcc_cfg_regs (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [3:0] wr_bank,
    input  wire logic [7:0] wr_data,
    input  wire logic       stop_recovery,
    output logic [7:0]      p3m_q,
    output logic [7:0]      port_configuration_q
);
    // mode register; a stop recovery keeps it, full reset clears it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            p3m_q <= `PCC_P3M_RESET;                    // R22
        end else if (wr_en && wr_addr == `PCC_P3M_ADDR) begin
            p3m_q <= wr_data;
        end else if (stop_recovery) begin
            p3m_q <= p3m_q;                             // R12
        end
    end

    // configuration register in bank f
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            port_configuration_q <= `PCC_PORT_CONFIGURATION_RESET;                  // R21
        end else if (wr_en && wr_addr == `PCC_PORT_CONFIGURATION_ADDR
                     && wr_bank == `PCC_PORT_CONFIGURATION_BANK) begin
            port_configuration_q <= wr_data;                          // R20
        end
    end
endmodule : pcc_cfg_regs

// ### design/pcc_port3_cmp.sv
`timescale 1ns/1ps
`include "pcc_defines.svh"
// Notes on behaviour
// R1: mode bit 1 selects analog lines 1-3
// R2: config bit 0 routes results to 4,5,7
// R3: analog mode: line three never interrupts
// R4: digital mode: line three normal input, irq
// R5: analog results interrupt on chosen edges
// R6: select 00 falling, 10 both lines
// R7: analog read returns results in d1,d2
// R8: result high when positive above reference
// R9: routing leaves stored output bits untouched
// R10: comparators disabled during stop
// R11: software selects digital before stop recovery
// R12: analog mode survives stop recovery reset
// R13: halt keeps comparators and interrupts running
// R14: line one feeds timer in both modes
// R15: mode bit 0 clear gives port2 open-drain
// R16: config d1 port1 push-pull, default one
// R17: config d2 port0 push-pull, default one
// R18: config d3-d6 low-emission per port
// R19: config d7 oscillator drive, default one
// R20: config register write-only, bank f 00h
// R21: config d0 resets zero, others one
// R22: full reset leaves port three plain
module pcc_port3_cmp (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wr_addr,
    input  wire logic [3:0]          wr_bank,
    input  wire logic [7:0]          wr_data,
    input  wire pcc_pkg::pcc_pwr_t   pwr_state,
    input  wire logic                stop_recovery,
    input  wire logic [7:0]          irq_reg,
    input  wire logic [7:0]          port_three_in,
    input  wire logic [7:0]          port_three_out,
    input  wire logic                cmp_a_raw,
    input  wire logic                cmp_b_raw,
    output logic [7:0]               port_three_read_q,
    output logic [7:0]               port_three_pin_q,
    output logic                     external_interrupt_one_q,
    output logic                     cmp_a_irq_q,
    output logic                     cmp_b_irq_q,
    output logic                     timer_in_q,
    output logic                     comparator_enable_q,
    output logic                     analog_mode_q,
    output logic                     port_two_push_pull_q,
    output logic                     port_one_push_pull_q,
    output logic                     port_zero_push_pull_q,
    output logic [3:0]               port_std_drive_q,
    output logic                     osc_std_drive_q
);
    logic [7:0]  p3m_q;
    logic [7:0]  port_configuration_q;
    logic        analog;
    logic        cmp_on;
    logic        comparator_a_result;
    logic        comparator_b_result;
    logic        line_three_q;
    logic        a_pulse;
    logic        b_pulse;
    logic        b_pulse_gated;
    logic        a_pulse_gated;
    logic [7:0]  read_d;
    logic [7:0]  pin_d;
    pcc_pkg::pcc_edge_t sel;

    pcc_cfg_regs u_regs (
        .mclk          (mclk),
        .resetn        (resetn),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_bank       (wr_bank),
        .wr_data       (wr_data),
        .stop_recovery (stop_recovery),
        .p3m_q         (p3m_q),
        .port_configuration_q        (port_configuration_q)
    );

    // mode decode and comparator enable
    assign analog = p3m_q[`PCC_P3M_ANALOG_BIT];              // R1
    assign cmp_on = analog && (pwr_state != pcc_pkg::PCC_PWR_STOP); // R10 R13

    // comparator results, forced low while comparators are off: high when positive above reference
    assign comparator_a_result = cmp_on & cmp_a_raw;        // R8
    assign comparator_b_result = cmp_on & cmp_b_raw;        // R8

    assign sel = pcc_pkg::pcc_edge_t'({irq_reg[`PCC_IRQ_SEL_HI_BIT],
                                       irq_reg[`PCC_IRQ_SEL_LO_BIT]});

    // edge detection, one detector per comparator
    logic [1:0]  result_vec;
    logic [1:0]  pulse_vec;
    assign result_vec = {comparator_b_result, comparator_a_result};

    for (genvar g = 0; g < 2; g++) begin : g_edge
        pcc_edge_det u_edge (
            .mclk   (mclk),
            .resetn (resetn),
            .enable (cmp_on),
            .level  (result_vec[g]),
            .sel    (sel),
            .pulse  (pulse_vec[g])
        );
    end

    // per-comparator pulses back on named nets
    assign a_pulse = pulse_vec[0];
    assign b_pulse = pulse_vec[1];

    // with falling select only line two reports; both for any other select
    always_comb begin
        a_pulse_gated = a_pulse;
        b_pulse_gated = b_pulse;
        if (sel == pcc_pkg::PCC_EDGE_FALL) begin
            a_pulse_gated = 1'b0;                           // R6
        end
    end

    // comparator interrupt pulses
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmp_a_irq_q <= 1'b0;
            cmp_b_irq_q <= 1'b0;
        end else begin
            cmp_a_irq_q <= a_pulse_gated;                   // R5 R13
            cmp_b_irq_q <= b_pulse_gated;                   // R5 R6
        end
    end

    // line three falling edge as interrupt one, digital mode only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            line_three_q             <= 1'b1;
            external_interrupt_one_q <= 1'b0;
        end else begin
            line_three_q <= port_three_in[`PCC_LINE_THREE];
            external_interrupt_one_q <= !analog && line_three_q
                && !port_three_in[`PCC_LINE_THREE];         // R3 R4
        end
    end

    // read path value
    always_comb begin
        read_d = port_three_in;
        if (analog) begin
            read_d[`PCC_LINE_ONE]   = comparator_a_result;  // R7
            read_d[`PCC_LINE_TWO]   = comparator_b_result;  // R7
            read_d[`PCC_LINE_THREE] = 1'b0;                 // R3
        end
    end

    // pin mux: stored register values kept, only the pins redirected
    always_comb begin
        pin_d = port_three_out;
        pin_d[3:0] = 4'h0;                                  // R22
        if (port_configuration_q[`PCC_PORT_CONFIGURATION_CMPOUT_BIT]) begin
            pin_d[`PCC_LINE_FOUR]  = comparator_a_result;   // R2 R9
            pin_d[`PCC_LINE_FIVE]  = comparator_b_result;   // R2 R9
            pin_d[`PCC_LINE_SEVEN] = comparator_b_result;   // R2 R9
        end
    end

    // registered port outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            port_three_read_q <= 8'h00;
            port_three_pin_q  <= 8'h00;
            timer_in_q        <= 1'b0;
        end else begin
            port_three_read_q <= read_d;
            port_three_pin_q  <= pin_d;
            timer_in_q <= analog ? comparator_a_result
                                 : port_three_in[`PCC_LINE_ONE]; // R14
        end
    end

    // drive and mode status outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            comparator_enable_q   <= 1'b0;
            analog_mode_q         <= 1'b0;
            port_two_push_pull_q  <= 1'b0;
            port_one_push_pull_q  <= 1'b1;
            port_zero_push_pull_q <= 1'b1;
            port_std_drive_q      <= 4'hf;
            osc_std_drive_q       <= 1'b1;
        end else begin
            comparator_enable_q   <= cmp_on;                // R10
            analog_mode_q         <= analog;                // R1 R12
            port_two_push_pull_q  <= p3m_q[`PCC_P3M_P2PP_BIT];   // R15
            port_one_push_pull_q  <= port_configuration_q[`PCC_PORT_CONFIGURATION_P1PP_BIT]; // R16
            port_zero_push_pull_q <= port_configuration_q[`PCC_PORT_CONFIGURATION_P0PP_BIT]; // R17
            port_std_drive_q <= port_configuration_q[`PCC_PORT_CONFIGURATION_EMI_LSB +: 4];  // R18
            osc_std_drive_q  <= port_configuration_q[`PCC_PORT_CONFIGURATION_OSC_BIT];       // R19
        end
    end
endmodule : pcc_port3_cmp

// ### bench/pcc_port3_monitor.sv
`timescale 1ns/1ps
// port-level checks for the port three comparator block
module pcc_port3_monitor (
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic              wr_en,
    input wire logic [7:0]        wr_addr,
    input wire logic [3:0]        wr_bank,
    input wire logic [7:0]        wr_data,
    input wire pcc_pkg::pcc_pwr_t pwr_state,
    input wire logic              cmp_a_raw,
    input wire logic              cmp_b_raw,
    input wire logic [7:0]        port_three_read_q,
    input wire logic [7:0]        port_three_pin_q,
    input wire logic              external_interrupt_one_q,
    input wire logic              cmp_a_irq_q,
    input wire logic              comparator_enable_q,
    input wire logic              analog_mode_q,
    input wire logic              port_two_push_pull_q,
    input wire logic              port_one_push_pull_q,
    input wire logic              port_zero_push_pull_q,
    input wire logic [3:0]        port_std_drive_q,
    input wire logic              osc_std_drive_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    logic mw;
    logic cw;
    // accepted writes to the two registers
    assign mw = wr_en && wr_addr == 8'hf7;
    assign cw = wr_en && wr_addr == 8'h00 && wr_bank == 4'hf;

    a_mode_write_lands:
    assert property (mw |-> ##2 {analog_mode_q, port_two_push_pull_q}
        == $past(wr_data[1:0], 2)) else $error("mode write lost");
    a_cfg_drive_lands:
    assert property (cw |-> ##2 {osc_std_drive_q, port_std_drive_q}
        == $past(wr_data[7:3], 2)) else $error("drive bits lost");
    a_cfg_pp_lands:
    assert property (cw |-> ##2 {port_zero_push_pull_q,
        port_one_push_pull_q} == $past(wr_data[2:1], 2))
        else $error("push-pull bits lost");
    a_cmp_enable_gate:
    assert property (comparator_enable_q == (analog_mode_q
        && $past(pwr_state) != pcc_pkg::PCC_PWR_STOP))
        else $error("comparator enable wrong");
    a_low_pins_zero:
    assert property (port_three_pin_q[3:0] == 4'h0)
        else $error("input lines driven");
    a_line3_quiet:
    assert property (analog_mode_q && $past(analog_mode_q)
        |-> !external_interrupt_one_q) else $error("line three irq");
    a_read_results:
    assert property (comparator_enable_q && $past(comparator_enable_q)
        && $stable(cmp_a_raw) && $stable(cmp_b_raw)
        && $past(cmp_a_raw, 2) == cmp_a_raw
        && $past(cmp_b_raw, 2) == cmp_b_raw
        |-> port_three_read_q[2:1] == {cmp_b_raw, cmp_a_raw})
        else $error("read bits differ from results");
    a_cmp_irq_gated:
    assert property (cmp_a_irq_q
        |-> comparator_enable_q || $past(comparator_enable_q))
        else $error("irq while comparators off");

    c_cfg_write: cover property (cw);
    c_cmp_irq: cover property (cmp_a_irq_q);
    c_line3_irq: cover property (external_interrupt_one_q);
endmodule : pcc_port3_monitor

bind pcc_port3_cmp pcc_port3_monitor u_mon (.*);

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic              mclk           = 1'b0;
    logic              resetn         = 1'b0;
    logic              wr_en          = 1'b0;
    logic [7:0]        wr_addr        = 8'h00;
    logic [3:0]        wr_bank        = 4'h0;
    logic [7:0]        wr_data        = 8'h00;
    pcc_pkg::pcc_pwr_t pwr_state      = pcc_pkg::PCC_PWR_RUN;
    logic              stop_recovery  = 1'b0;
    logic [7:0]        irq_reg        = 8'h00;
    logic [7:0]        port_three_in  = 8'h0a;
    logic [7:0]        port_three_out = 8'hb0;
    logic              cmp_a_raw      = 1'b0;
    logic              cmp_b_raw      = 1'b0;
    logic [7:0]        port_three_read_q, port_three_pin_q;
    logic              external_interrupt_one_q, cmp_a_irq_q, cmp_b_irq_q;
    logic              timer_in_q, comparator_enable_q, analog_mode_q;
    logic              port_two_push_pull_q, port_one_push_pull_q;
    logic              port_zero_push_pull_q, osc_std_drive_q;
    logic [3:0]        port_std_drive_q;
    logic [7:0]        n_a, n_b, n_e;
    logic              cnt_on = 1'b0;
    logic              cnt_clr = 1'b0;
    int                err_total = 0;
    int                num_checks = 0;

    pcc_port3_cmp u_dut (.*);

    // free-running clock
    always #25 mclk = ~mclk;

    // interrupt pulse counters
    always @(posedge mclk) begin
        if (cnt_clr) begin
            n_a <= 8'h00;
            n_b <= 8'h00;
            n_e <= 8'h00;
        end else if (cnt_on) begin
            n_a <= n_a + {7'h00, cmp_a_irq_q};
            n_b <= n_b + {7'h00, cmp_b_irq_q};
            n_e <= n_e + {7'h00, external_interrupt_one_q};
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [7:0] d);
        wr_addr = a;
        wr_bank = b;
        wr_data = d;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        tick(3);
    endtask : wr

    // raise then drop results and line three, counting pulses
    task automatic edges(input logic [7:0] sel, input logic [7:0] ea,
                         input logic [7:0] eb, input logic [7:0] ee);
        irq_reg = sel;
        cnt_clr = 1'b1;
        tick(4);
        cnt_clr = 1'b0;
        cnt_on = 1'b1;
        {cmp_b_raw, cmp_a_raw, port_three_in[3]} = 3'b111;
        tick(4);
        {cmp_b_raw, cmp_a_raw, port_three_in[3]} = 3'b000;
        tick(4);
        cnt_on = 1'b0;
        chk(n_a, ea);
        chk(n_b, eb);
        chk(n_e, ee);
    endtask : edges

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        static logic [7:0] cfg [3] = '{8'h55, 8'haa, 8'hfe};
        tick(5);
        resetn = 1'b1;
        tick(2);
        chk({analog_mode_q, port_two_push_pull_q, port_one_push_pull_q,
             port_zero_push_pull_q, comparator_enable_q, 3'h0},
            8'h30);
        chk({osc_std_drive_q, port_std_drive_q, 3'h0}, 8'hf8);
        chk(port_three_pin_q, 8'hb0);
        $display("test reset done");
        foreach (cfg[i]) begin
            wr(8'h00, 4'hf, cfg[i]);
            chk({osc_std_drive_q, port_std_drive_q, port_zero_push_pull_q,
                 port_one_push_pull_q, 1'b0},
                cfg[i] & 8'hfe);
        end
        wr(8'h00, 4'he, 8'h00);
        wr(8'h01, 4'hf, 8'h00);
        chk({osc_std_drive_q, port_std_drive_q, 3'h0}, 8'hf8);
        $display("test config done");
        wr(8'hf7, 4'h0, 8'h01);
        chk({5'h00, analog_mode_q, port_two_push_pull_q,
             comparator_enable_q}, 8'h02);
        chk(port_three_read_q, 8'h0a);
        chk({7'h00, timer_in_q}, 8'h01);
        wr(8'hf7, 4'h0, 8'h02);
        chk({5'h00, analog_mode_q, port_two_push_pull_q,
             comparator_enable_q}, 8'h05);
        for (int i = 0; i < 4; i++) begin
            {cmp_b_raw, cmp_a_raw} = i[1:0];
            tick(3);
            chk({4'h0, port_three_read_q[3:1], timer_in_q},
                {4'h0, 1'b0, i[1:0], i[0]});
        end
        {cmp_b_raw, cmp_a_raw} = 2'b01;
        wr(8'h00, 4'hf, 8'hff);
        chk(port_three_pin_q, 8'h10);
        wr(8'h00, 4'hf, 8'hfe);
        chk(port_three_pin_q, 8'hb0);
        $display("test analog done");
        pwr_state = pcc_pkg::PCC_PWR_HALT;
        edges(8'h00, 8'h00, 8'h01, 8'h00);
        edges(8'h40, 8'h01, 8'h01, 8'h00);
        edges(8'h80, 8'h02, 8'h02, 8'h00);
        edges(8'hc0, 8'h01, 8'h01, 8'h00);
        wr(8'hf7, 4'h0, 8'h00);
        edges(8'h80, 8'h00, 8'h00, 8'h01);
        $display("test interrupts done");
        wr(8'hf7, 4'h0, 8'h02);
        {cmp_b_raw, cmp_a_raw} = 2'b11;
        pwr_state = pcc_pkg::PCC_PWR_STOP;
        tick(3);
        chk({4'h0, port_three_read_q[2:1], comparator_enable_q,
             analog_mode_q}, 8'h01);
        stop_recovery = 1'b1;
        tick(1);
        stop_recovery = 1'b0;
        pwr_state = pcc_pkg::PCC_PWR_RUN;
        tick(3);
        chk({4'h0, port_three_read_q[2:1], comparator_enable_q,
             analog_mode_q}, 8'h0f);
        // digital mode before stop keeps lines one to three sensed
        wr(8'hf7, 4'h0, 8'h00);
        pwr_state = pcc_pkg::PCC_PWR_STOP;
        port_three_in[3:1] = 3'b101;
        tick(3);
        chk({port_three_read_q[7:1], timer_in_q}, 8'h0b);
        pwr_state = pcc_pkg::PCC_PWR_RUN;
        tick(1);
        $display("test stop done");
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
